// File: design/asc_defines.vh
// Purpose: constants for the converter sequencer control block
// Assumes: 32-bit apb, word per register, byte address = 4 * index
// Notes: register indices follow the printed word offsets
`ifndef ASC_DEFINES_VH
`define ASC_DEFINES_VH
`define ASC_IDX_CTRL1 8'h00
`define ASC_IDX_CTRL2 8'h01
`define ASC_IDX_MAXCONV 8'h02
`define ASC_IDX_CHSEL0 8'h03
`define ASC_IDX_STATUS 8'h07
`define ASC_IDX_RES_LEFT 8'h08
`define ASC_IDX_CTRL3 8'h18
`define ASC_IDX_ST 8'h19
`define ASC_IDX_REFSEL 8'h1C
`define ASC_IDX_RES_RIGHT 8'h40
`define ASC_CTRL1_RST 16'h0000
`define ASC_CTRL2_RST 16'h0000
`define ASC_CTRL3_RST 16'h0000
`define ASC_MAXCONV_RST 16'h0000
`define ASC_REFSEL_RST 16'h0000
`define ASC_CHSEL_RST 16'h0000
`define ASC_REFSEL_LO 14
`define ASC_REFSEL_HI 15
`define ASC_C1_STARTSTOP 6
`define ASC_C1_CASCADE 4
`define ASC_C1_ACQ_LO 8
`define ASC_C1_ACQ_HI 11
`define ASC_C2_SOFT_A 13
`define ASC_C2_PWM_A 8
`define ASC_C2_INT2_A 15
`define ASC_C2_EVERY2_A 10
`define ASC_C2_SOFT_B 5
`define ASC_C2_PWM_B 0
`define ASC_C2_EVERY2_B 2
`define ASC_C2_RST_A 14
`define ASC_C2_RST_B 6
`define ASC_C3_CLKDIV_LO 1
`define ASC_C3_CLKDIV_HI 4
`define ASC_CONV_NS 160
`define ASC_CLK_NS 20
`define ASC_CONV_CYC ((`ASC_CONV_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_FULL_SCALE 12'hFFF
`endif

// File: design/asc_result_mem.v
// Purpose: sixteen result words, one write port, registered read
// Assumes: single clock, write and read may share a cycle
// Notes: read data is the stored word from the previous edge
module asc_result_mem (
    input wire pclk,
    input wire we,
    input wire [3:0] waddr,
    input wire [11:0] wdata,
    input wire [3:0] raddr,
    output reg [11:0] rdata
);
    reg [11:0] mem [0:15];
    always @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// File: design/asc_seq_ctrl.v
// Purpose: autosequencer, triggers, pacing and apb registers of the
//   12-bit sixteen input converter control
// Assumes: converter core outside takes a channel and returns a code
// Notes: result memory is a separate module
// Summary of operation
// - codes clamp at 0 and 4095; truncated linear code from converter
// - cascaded: each step selects any one of the sixteen input channels
// - up to sixteen conversions follow one start trigger
// - two independent 8-state sequencers or one cascaded 16-state one
// - both sequencers share one converter; requests are serialised
// - dual mode: each sequencer uses only its own eight inputs
// - each result goes to the result word of its step
// - the same channel may be chosen in several steps
// - start by software, pwm trigger or external interrupt two
// - interrupt every end of sequence or every second one
// - start/stop mode halts after each conversion and resumes on next trigger
// - in dual mode trigger a and b start their sequencers apart
// - acquisition window is counted in clock divide ticks, no prescale of its own
// - one conversion lasts 160 ns at a 50 MHz converter clock
// - registers and sequencer on system clock, acquisition on peripheral clock enable
// - in reset gate is low, registers reset, analog off
// - after reset registers frozen until clock gate set high
// - halt powers analog down and keeps registers
// - reference select bits 15:14 choose the external reference
// - results readable left-justified and right-justified
//
// Register access over APB and the address map were left to the implementer.
`include "asc_defines.vh"
module asc_seq_ctrl (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire converter_clock_gate,
    input wire halt,
    input wire enhanced_pulse_width_modules_a,
    input wire enhanced_pulse_width_modules_b,
    input wire external_interrupt_two,
    output reg [3:0] conv_channel,
    output reg conv_start,
    output reg conv_sample,
    input wire conv_done,
    input wire [12:0] conv_code,
    output wire analog_powered,
    output wire [1:0] external_reference_input,
    output reg seq_a_irq,
    output reg seq_b_irq
);
    localparam S_IDLE = 2'b00;
    localparam S_ACQ = 2'b01;
    localparam S_CONV = 2'b10;
    localparam S_STORE = 2'b11;
    reg [15:0] ctrl1_r, ctrl2_r, ctrl3_r, maxconv_r, refsel_r;
    reg [15:0] chsel_r [0:3];
    reg [1:0] state_r;
    reg [3:0] ptr_a_r, ptr_b_r, step_r;
    reg busy_a_r, busy_b_r, pend_a_r, pend_b_r, cur_b_r;
    reg eos_cnt_a_r, eos_cnt_b_r;
    reg [7:0] acq_cnt_r;
    reg [7:0] conv_cnt_r;
    reg [3:0] div_cnt_r;
    reg [1:0] pwm_a_s, pwm_b_s, int2_s;
    reg pwm_a_d, pwm_b_d, int2_d;
    reg [11:0] code_r;
    reg rd_pending_r;
    reg [31:0] rdata_r;
    wire [11:0] mem_rdata;
    wire reg_clk_en;
    wire tick;
    wire cascade;
    wire startstop;
    wire wr_acc;
    wire [7:0] widx;
    wire trig_a, trig_b;
    wire last_a, last_b;
    wire [3:0] maxa, maxb;
    wire [15:0] cur_sel;
    wire [3:0] cur_nib;
    wire result_rd;
    wire res_right;
    wire [3:0] res_idx;
    integer i;

    // register clock gated off until gate high; reset still applies
    assign reg_clk_en = converter_clock_gate & ~halt;
    assign analog_powered = converter_clock_gate & ~halt;
    assign external_reference_input =
        refsel_r[`ASC_REFSEL_HI:`ASC_REFSEL_LO];
    assign cascade = ctrl1_r[`ASC_C1_CASCADE];
    assign startstop = ctrl1_r[`ASC_C1_STARTSTOP];
    assign widx = paddr[9:2];
    assign wr_acc = psel & penable & pwrite & reg_clk_en;
    assign res_right = widx[7:4] == 4'h4;
    assign result_rd = (widx[7:4] == 4'h0 && widx[3]) ||
        (widx[7:4] == 4'h1 && ~widx[3]) || res_right;
    assign res_idx = res_right ? widx[3:0] : (widx[3:0] - 4'h8);

    // read of results waits one cycle for the registered memory
    assign pready = ~(psel & ~pwrite & result_rd & ~rd_pending_r);
    assign pslverr = 1'b0;
    assign prdata = rdata_r;

    // peripheral clock enable divided from the system clock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 4'h0;
        end else if (reg_clk_en) begin
            if (div_cnt_r >= ctrl3_r[`ASC_C3_CLKDIV_HI:`ASC_C3_CLKDIV_LO])
                div_cnt_r <= 4'h0;
            else
                div_cnt_r <= div_cnt_r + 4'h1;
        end
    end
    assign tick = reg_clk_en &&
        div_cnt_r >= ctrl3_r[`ASC_C3_CLKDIV_HI:`ASC_C3_CLKDIV_LO];

    // trigger pins synchronised and edge detected
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_a_s <= 2'b00;
            pwm_b_s <= 2'b00;
            int2_s <= 2'b00;
            pwm_a_d <= 1'b0;
            pwm_b_d <= 1'b0;
            int2_d <= 1'b0;
        end else begin
            pwm_a_s <= {pwm_a_s[0], enhanced_pulse_width_modules_a};
            pwm_b_s <= {pwm_b_s[0], enhanced_pulse_width_modules_b};
            int2_s <= {int2_s[0], external_interrupt_two};
            pwm_a_d <= pwm_a_s[1];
            pwm_b_d <= pwm_b_s[1];
            int2_d <= int2_s[1];
        end
    end
    assign trig_a = (wr_acc && widx == `ASC_IDX_CTRL2 &&
            pwdata[`ASC_C2_SOFT_A]) ||
        (ctrl2_r[`ASC_C2_PWM_A] && pwm_a_s[1] && !pwm_a_d) ||
        (ctrl2_r[`ASC_C2_INT2_A] && int2_s[1] && !int2_d);
    assign trig_b = ~cascade && ((wr_acc && widx == `ASC_IDX_CTRL2 &&
            pwdata[`ASC_C2_SOFT_B]) ||
        (ctrl2_r[`ASC_C2_PWM_B] && pwm_b_s[1] && !pwm_b_d));

    // sequence lengths: cascaded up to 16, dual up to 8 each
    assign maxa = cascade ? maxconv_r[3:0] :
        {1'b0, maxconv_r[2:0]};
    assign maxb = {1'b0, maxconv_r[6:4]};
    assign last_a = ptr_a_r == maxa;
    assign last_b = ptr_b_r == maxb;

    // channel for the current step; any channel per step, repeats allowed
    assign cur_sel = chsel_r[step_r[3:2]];
    assign cur_nib = cur_sel[{step_r[1:0], 2'b00} +: 4];

    // register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_r <= `ASC_CTRL1_RST;
            ctrl2_r <= `ASC_CTRL2_RST;
            ctrl3_r <= `ASC_CTRL3_RST;
            maxconv_r <= `ASC_MAXCONV_RST;
            refsel_r <= `ASC_REFSEL_RST;
            for (i = 0; i < 4; i = i + 1)
                chsel_r[i] <= `ASC_CHSEL_RST;
        end else if (wr_acc) begin
            case (widx)
                `ASC_IDX_CTRL1: ctrl1_r <= pwdata[15:0];
                `ASC_IDX_CTRL2: ctrl2_r <= pwdata[15:0] &
                    ~(16'h0001 << `ASC_C2_SOFT_A) &
                    ~(16'h0001 << `ASC_C2_SOFT_B);
                `ASC_IDX_CTRL3: ctrl3_r <= pwdata[15:0];
                `ASC_IDX_MAXCONV: maxconv_r <= pwdata[15:0];
                `ASC_IDX_REFSEL: refsel_r <= pwdata[15:0];
                default: begin
                    if (widx >= `ASC_IDX_CHSEL0 && widx < `ASC_IDX_STATUS)
                        chsel_r[widx[1:0] - 2'b11] <= pwdata[15:0];
                end
            endcase
        end
    end

    // sequencer and shared converter arbiter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= S_IDLE;
            ptr_a_r <= 4'h0;
            ptr_b_r <= 4'h0;
            step_r <= 4'h0;
            busy_a_r <= 1'b0;
            busy_b_r <= 1'b0;
            pend_a_r <= 1'b0;
            pend_b_r <= 1'b0;
            cur_b_r <= 1'b0;
            eos_cnt_a_r <= 1'b0;
            eos_cnt_b_r <= 1'b0;
            acq_cnt_r <= 8'h00;
            conv_cnt_r <= 8'h00;
            conv_channel <= 4'h0;
            conv_start <= 1'b0;
            conv_sample <= 1'b0;
            code_r <= 12'h000;
            seq_a_irq <= 1'b0;
            seq_b_irq <= 1'b0;
        end else if (reg_clk_en) begin
            conv_start <= 1'b0;
            seq_a_irq <= 1'b0;
            seq_b_irq <= 1'b0;
            // a trigger while running is remembered, set wins over clear
            if (trig_a)
                pend_a_r <= 1'b1;
            if (trig_b)
                pend_b_r <= 1'b1;
            if (wr_acc && widx == `ASC_IDX_CTRL2 &&
                    pwdata[`ASC_C2_RST_A])
                ptr_a_r <= 4'h0;
            if (wr_acc && widx == `ASC_IDX_CTRL2 &&
                    pwdata[`ASC_C2_RST_B])
                ptr_b_r <= 4'h0;
            case (state_r)
                S_IDLE: begin
                    // sequencer a served first, one converter only
                    if (pend_a_r || busy_a_r) begin
                        if (!trig_a)
                            pend_a_r <= 1'b0;
                        busy_a_r <= 1'b1;
                        cur_b_r <= 1'b0;
                        step_r <= ptr_a_r;
                        state_r <= S_ACQ;
                    end else if (pend_b_r || busy_b_r) begin
                        if (!trig_b)
                            pend_b_r <= 1'b0;
                        busy_b_r <= 1'b1;
                        cur_b_r <= 1'b1;
                        step_r <= {1'b1, ptr_b_r[2:0]};
                        state_r <= S_ACQ;
                    end
                    acq_cnt_r <= 8'h00;
                end
                S_ACQ: begin
                    // own eight inputs in dual mode, all sixteen cascaded
                    conv_channel <= cascade ? cur_nib :
                        {cur_b_r, cur_nib[2:0]};
                    conv_sample <= 1'b1;
                    if (tick) begin
                        if (acq_cnt_r > {4'h0,
                                ctrl1_r[`ASC_C1_ACQ_HI:`ASC_C1_ACQ_LO]}) begin
                            conv_sample <= 1'b0;
                            conv_start <= 1'b1;
                            conv_cnt_r <= 8'h00;
                            state_r <= S_CONV;
                        end else begin
                            acq_cnt_r <= acq_cnt_r + 8'h01;
                        end
                    end
                end
                S_CONV: begin
                    // least conversion time enforced before accepting a code
                    if (conv_cnt_r < `ASC_CONV_CYC)
                        conv_cnt_r <= conv_cnt_r + 8'h01;
                    else if (conv_done) begin
                        if (conv_code[12])
                            code_r <= 12'h000;
                        else
                            code_r <= conv_code[11:0];
                        state_r <= S_STORE;
                    end
                end
                S_STORE: begin
                    state_r <= S_IDLE;
                    if (!cur_b_r) begin
                        if (last_a) begin
                            busy_a_r <= 1'b0;
                            eos_cnt_a_r <= ~eos_cnt_a_r;
                            seq_a_irq <= !ctrl2_r[`ASC_C2_EVERY2_A] ||
                                eos_cnt_a_r;
                            if (!startstop)
                                ptr_a_r <= 4'h0;
                        end else begin
                            ptr_a_r <= ptr_a_r + 4'h1;
                            busy_a_r <= ~startstop;
                        end
                    end else begin
                        if (last_b) begin
                            busy_b_r <= 1'b0;
                            eos_cnt_b_r <= ~eos_cnt_b_r;
                            seq_b_irq <= !ctrl2_r[`ASC_C2_EVERY2_B] ||
                                eos_cnt_b_r;
                            if (!startstop)
                                ptr_b_r <= 4'h0;
                        end else begin
                            ptr_b_r <= ptr_b_r + 4'h1;
                            busy_b_r <= ~startstop;
                        end
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    asc_result_mem u_mem (
        .pclk(pclk),
        .we(reg_clk_en && state_r == S_STORE),
        .waddr(step_r),
        .wdata(code_r),
        .raddr(res_idx),
        .rdata(mem_rdata)
    );

    // read data register; results both left- and right-justified
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_pending_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end else begin
            rd_pending_r <= psel & penable & ~pwrite & result_rd &
                ~rd_pending_r;
            if (psel & penable & ~pwrite & result_rd & ~rd_pending_r) begin
                if (res_right)
                    rdata_r <= {20'h00000, mem_rdata};
                else
                    rdata_r <= {16'h0000, mem_rdata, 4'h0};
            end else if (psel & ~penable & ~pwrite) begin
                case (widx)
                    `ASC_IDX_CTRL1: rdata_r <= {16'h0000, ctrl1_r};
                    `ASC_IDX_CTRL2: rdata_r <= {16'h0000, ctrl2_r};
                    `ASC_IDX_CTRL3: rdata_r <= {16'h0000, ctrl3_r};
                    `ASC_IDX_MAXCONV: rdata_r <= {16'h0000, maxconv_r};
                    `ASC_IDX_REFSEL: rdata_r <= {16'h0000, refsel_r};
                    `ASC_IDX_STATUS: rdata_r <= {24'h000000,
                        ptr_b_r, ptr_a_r};
                    `ASC_IDX_ST: rdata_r <= {26'h0000000, eos_cnt_b_r,
                        eos_cnt_a_r, busy_b_r, busy_a_r,
                        state_r};
                    default: begin
                        if (widx >= `ASC_IDX_CHSEL0 &&
                                widx < `ASC_IDX_STATUS)
                            rdata_r <= {16'h0000,
                                chsel_r[widx[1:0] - 2'b11]};
                        else
                            rdata_r <= 32'h00000000;
                    end
                endcase
            end
        end
    end
endmodule

// File: verification/asc_conv_model.sv
// Purpose: behavioural converter core facing the sequencer control
// Assumes: one code per start pulse, answered lat cycles later
// Notes: code bus toggles every cycle outside the answer cycle
module asc_conv_model (
    input wire pclk,
    input wire presetn,
    input wire conv_start,
    input wire [3:0] conv_channel,
    input wire [7:0] lat,
    output logic conv_done,
    output logic [12:0] conv_code
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    int mv;
    logic [3:0] ch;
    assign mv = int'(ch) * 210 - 10;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            conv_done <= 1'b0;
            conv_code <= 13'h0000;
        end else begin
            conv_done <= (cnt == 1);
            conv_code <= ~conv_code;
            if (conv_start) begin
                cnt <= lat;
                ch <= conv_channel;
            end else if (cnt > 0)
                cnt <= cnt - 1;
            if (cnt == 1)
                conv_code <= mv <= 0 ? 13'h1000 : mv >= 3000 ? 13'h0FFF
                    : 13'((4096 * mv) / 3000);
        end
    end
endmodule

// File: verification/asc_seq_ctrl_assertions.sv
// Purpose: port checks for the sequencer control block
// Assumes: one clock, converter answers 8 or more cycles after start
// Notes: bound to every instance of the block
module asc_seq_ctrl_assertions (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire converter_clock_gate,
    input wire halt,
    input wire enhanced_pulse_width_modules_a,
    input wire enhanced_pulse_width_modules_b,
    input wire external_interrupt_two,
    input wire [3:0] conv_channel,
    input wire conv_start,
    input wire conv_sample,
    input wire conv_done,
    input wire [12:0] conv_code,
    input wire analog_powered,
    input wire [1:0] external_reference_input,
    input wire seq_a_irq,
    input wire seq_b_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire ref_wr = psel && penable && pwrite && paddr == 12'h070;
    wire left_setup = psel && !penable && paddr >= 12'h020
        && paddr < 12'h060;
    sequence quiet8;
        !conv_start [*8];
    endsequence
    sequence one_wait;
        !pready ##1 pready;
    endsequence
    no_error_resp_a: assert property (!pslverr)
        else $error("apb error response seen");
    reg_no_wait_a: assert property (
        psel && penable && paddr < 12'h020 |-> pready)
        else $error("register access waited");
    left_result_wait_a: assert property (left_setup |=> one_wait)
        else $error("left result read timing wrong");
    analog_power_a: assert property (
        analog_powered == (converter_clock_gate && !halt))
        else $error("analog power state wrong");
    ref_hold_a: assert property (!ref_wr |=>
        $stable(external_reference_input))
        else $error("reference select moved without write");
    one_converter_a: assert property (conv_start |=> quiet8)
        else $error("conversion started while busy");
    window_first_a: assert property ($rose(conv_start)
        |-> $past(conv_sample)) else $error("start without window");
    channel_hold_a: assert property (conv_start
        |-> $stable(conv_channel)) else $error("channel moved at start");
    irq_a_pulse_a: assert property (seq_a_irq |=> !seq_a_irq)
        else $error("interrupt a longer than a cycle");
    irq_b_pulse_a: assert property (seq_b_irq |=> !seq_b_irq)
        else $error("interrupt b longer than a cycle");
    halt_no_start_a: assert property (halt && $past(halt)
        |-> !conv_start) else $error("conversion during halt");
endmodule
bind asc_seq_ctrl asc_seq_ctrl_assertions u_asc_seq_ctrl_assertions (.*);

// File: verification/adc_sequencer_control_bench.sv
// Purpose: self-checking bench for the sequencer control block
// Assumes: converter model answers after 8 or 20 cycles
// Notes: input k carries k * 210 - 10 millivolts
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
    bad_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module adc_sequencer_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, halt, conv_start;
    logic converter_clock_gate, conv_sample, pready, pslverr;
    logic enhanced_pulse_width_modules_a, enhanced_pulse_width_modules_b;
    logic external_interrupt_two, conv_done, analog_powered;
    logic seq_a_irq, seq_b_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [3:0] conv_channel;
    logic [12:0] conv_code;
    logic [1:0] external_reference_input;
    logic [7:0] lat;
    int bad_count, checks, cyc, na, nb, sc;
    logic [3:0] chq[$];
    asc_seq_ctrl u_asc_seq_ctrl (.*);
    asc_conv_model u_asc_conv_model (.*);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (conv_start === 1'b1) chq.push_back(conv_channel);
        if (seq_a_irq === 1'b1) na++;
        if (seq_b_irq === 1'b1) nb++;
        if (conv_sample === 1'b1) sc++;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict;
        end
    end
    function automatic logic [11:0] code_of(input int ch);
        int mv;
        mv = ch * 210 - 10;
        if (mv <= 0) return 12'h000;
        if (mv >= 3000) return 12'hFFF;
        return 12'((4096 * mv) / 3000);
    endfunction
    function automatic logic [3:0] ch5(input int k);
        return 4'(5 * k);
    endfunction
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        d = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic kick;
        external_interrupt_two <= 1'b1;
        repeat (4) @(posedge pclk);
        external_interrupt_two <= 1'b0;
    endtask
    task automatic t_gate;
        wr(12'h000, 32'h0000_0010);
        rd(12'h000);
        `CHK("ctrl1 frozen", 32'h0, d)
        `CHK("analog off", 1'b0, analog_powered)
        converter_clock_gate <= 1'b1;
        repeat (50) @(posedge pclk);
        `CHK("analog on", 1'b1, analog_powered)
    endtask
    task automatic t_regs;
        rd(12'h070);
        `CHK("refsel reset", 32'h0, d)
        wr(12'h070, 32'h0000_C000);
        rd(12'h070);
        `CHK("refsel", 32'h0000_C000, d)
        `CHK("ref pins", 2'h3, external_reference_input)
        wr(12'h074, 32'h0000_FFFF);
        rd(12'h074);
        `CHK("unmapped", 32'h0, d)
    endtask
    task automatic t_cascade;
        wr(12'h000, 32'h0000_0310);
        wr(12'h008, 32'h0000_000F);
        for (int j = 0; j < 4; j++)
            wr(12'h00C + 12'(4 * j), {16'h0, ch5(4 * j + 3),
                ch5(4 * j + 2), ch5(4 * j + 1), ch5(4 * j)});
        chq.delete();
        sc = 0;
        na = 0;
        wr(12'h004, 32'h0000_2000);
        while (na < 1) @(posedge pclk);
        `CHK("steps", 16, chq.size())
        `CHK("window", 64, sc)
        for (int k = 0; k < 16; k++) begin
            `CHK("channel", ch5(k), chq[k])
            rd(12'h100 + 12'(4 * k));
            `CHK("right", {20'h0, code_of(k * 5 % 16)}, d)
            rd(12'h020 + 12'(4 * k));
            `CHK("left", {16'h0, code_of(k * 5 % 16), 4'h0}, d)
        end
        rd(12'h01C);
        `CHK("pointer", 4'h0, d[3:0])
    endtask
    task automatic t_dual;
        wr(12'h000, 32'h0);
        wr(12'h008, 32'h0000_0011);
        wr(12'h00C, 32'h0000_0022);
        wr(12'h014, 32'h0000_00BA);
        wr(12'h004, 32'h0000_0101);
        chq.delete();
        na = 0;
        nb = 0;
        lat <= 8'h14;
        enhanced_pulse_width_modules_a <= 1'b1;
        enhanced_pulse_width_modules_b <= 1'b1;
        repeat (4) @(posedge pclk);
        enhanced_pulse_width_modules_a <= 1'b0;
        enhanced_pulse_width_modules_b <= 1'b0;
        while (na < 1 || nb < 1) @(posedge pclk);
        `CHK("conversions", 4, chq.size())
        rd(12'h104);
        `CHK("repeat input", {20'h0, code_of(2)}, d)
        rd(12'h120);
        `CHK("group b", {20'h0, code_of(10)}, d)
        rd(12'h124);
        `CHK("group b 2", {20'h0, code_of(11)}, d)
    endtask
    task automatic t_every2;
        wr(12'h00C, 32'h0000_0055);
        wr(12'h004, 32'h0000_8400);
        na = 0;
        chq.delete();
        kick;
        while (chq.size() < 2) @(posedge pclk);
        repeat (60) @(posedge pclk);
        `CHK("first end", 0, na)
        rd(12'h100);
        `CHK("int2 start", {20'h0, code_of(5)}, d)
        kick;
        while (na < 1) @(posedge pclk);
        `CHK("second end", 4, chq.size())
    endtask
    task automatic t_startstop;
        wr(12'h004, 32'h0);
        wr(12'h000, 32'h0000_0040);
        na = 0;
        chq.delete();
        wr(12'h004, 32'h0000_2000);
        repeat (80) @(posedge pclk);
        `CHK("one per trigger", 1, chq.size())
        `CHK("no end yet", 0, na)
        wr(12'h004, 32'h0000_2000);
        while (na < 1) @(posedge pclk);
        `CHK("resumed", 2, chq.size())
    endtask
    task automatic t_halt;
        halt <= 1'b1;
        chq.delete();
        wr(12'h004, 32'h0000_2000);
        repeat (40) @(posedge pclk);
        `CHK("halted", 0, chq.size())
        `CHK("analog down", 1'b0, analog_powered)
        rd(12'h070);
        `CHK("kept", 32'h0000_C000, d)
        halt <= 1'b0;
    endtask
    task automatic print_verdict;
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, halt, converter_clock_gate} = '0;
        enhanced_pulse_width_modules_a = 1'b0;
        enhanced_pulse_width_modules_b = 1'b0;
        external_interrupt_two = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        lat = 8'h08;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_gate;
        t_regs;
        t_cascade;
        t_dual;
        t_every2;
        t_startstop;
        t_halt;
        print_verdict;
    end
endmodule
